// ===== common/brkseq_pkg.sv
// Purpose: Types for the brake control sequencer
// Assumes: Nothing beyond the constants header
// Notes: State codes are written out in binary
`default_nettype none
package brkseq_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BRK_IDLE = 3'b000,
    BRK_OPEN_WAIT = 3'b001,
    BRK_START_WAIT = 3'b010,
    BRK_RUN = 3'b011,
    BRK_STILL_WAIT = 3'b100,
    BRK_CLOSE_WAIT = 3'b101,
    BRK_POWER_WAIT = 3'b110
  } brkseq_state_t;

endpackage
`default_nettype wire

// ===== common/brkseq_pwm_if.sv
// Purpose: Carrier between the sequencer and its brake PWM generator
// Assumes: Single sys_clk domain
// Notes: Settings are passed raw; the generator clamps them
`timescale 1ns/10ps
`default_nettype none
interface brkseq_pwm_if;
  logic [31:0] freq;
  logic [31:0] duty;
  logic release_brake;
  logic pwm_out;

  modport ctl (output freq, output duty, output release_brake, input pwm_out);
  modport gen (input freq, input duty, input release_brake, output pwm_out);
endinterface
`default_nettype wire

// ===== common/brkseq_regs.svh
// Purpose: Constants for the brake control sequencer
// Assumes: 20 MHz sys_clk; configuration entries addressed by subindex
// Notes: Offsets are subindex numbers; each entry holds up to 32 bits
//
// Contract
// R1 - All four sequencing delays are unsigned 32-bit millisecond counts.
// R2 - After motor standstill, wait the close-brake idle delay (default 1000 ms) before engaging the brake.
// R3 - After engaging the brake, wait the power-off idle delay (default 1000 ms) before removing motor current.
// R4 - After switching motor current on, wait the open-brake delay (default 1000 ms) before releasing the brake.
// R5 - After releasing the brake, wait the start-operation delay (default 0) before flagging operation ready.
// R6 - PWM frequency is in hertz, host writes 0..2000, brake output limit 50 is ambiguous, default 0.
// R7 - PWM duty is in percent, host writes 0 or 2..100, and the output follows that duty; here duty 0 gives a steady level, high while released.
// R8 - The brake output is a PWM at the programmed frequency and duty.
// R9 - Delay timers count a 1 ms tick from sys_clk, start on their event, fire on reaching the value, zero fires at once.
`ifndef BRKSEQ_REGS_SVH
`define BRKSEQ_REGS_SVH

// ----------------------------------------------------------------
// Entry subindices
// ----------------------------------------------------------------
`define BRK_SUB_COUNT 8'h00
`define BRK_SUB_CLOSE 8'h01
`define BRK_SUB_POWER 8'h02
`define BRK_SUB_OPEN 8'h03
`define BRK_SUB_START 8'h04
`define BRK_SUB_FREQ 8'h05
`define BRK_SUB_DUTY 8'h06

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BRK_ENTRY_COUNT 8'h06
`define BRK_CLOSE_RST 32'h0000_03e8
`define BRK_POWER_RST 32'h0000_03e8
`define BRK_OPEN_RST 32'h0000_03e8
`define BRK_START_RST 32'h0000_0000
`define BRK_FREQ_RST 32'h0000_0000
`define BRK_DUTY_RST 32'h0000_0000

// ----------------------------------------------------------------
// Timing and PWM limits
// ----------------------------------------------------------------
`define BRK_SYS_CLK_HZ 32'h0131_2d00
`define BRK_HZ_PER_KHZ 32'h0000_03e8
`define BRK_TICK_MS 32'h0000_0001
`define BRK_FREQ_MAX 11'h7d0
`define BRK_DUTY_FULL 7'h64
`define BRK_PWM_STEP_LAST 7'h63

`endif

// ===== logic/brkseq_pwm.sv
// Purpose: Software-style PWM for the holding brake output
// Assumes: sys_clk at 20 MHz; 100 duty steps per period
// Notes: Frequency 0, duty 0 or duty 100 give a steady level
`timescale 1ns/10ps
`default_nettype none
`include "brkseq_regs.svh"
module brkseq_pwm (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Sequencer side
  brkseq_pwm_if.gen pwm
);

  // ----------------------------------------------------------------
  // Setting clamps
  // ----------------------------------------------------------------
  // Out-of-range writes are the host's fault; clamp so the generator never aliases
  wire logic freq_big = (pwm.freq > {21'h0, `BRK_FREQ_MAX});
  wire logic [10:0] freq_c = freq_big ? `BRK_FREQ_MAX : pwm.freq[10:0];
  wire logic duty_full = (pwm.duty >= {25'h0, `BRK_DUTY_FULL});
  wire logic [6:0] duty_c = duty_full ? `BRK_DUTY_FULL : pwm.duty[6:0];
  wire logic active = pwm.release_brake && (freq_c != 11'h000) && (duty_c != 7'h00) && !duty_full; // see R7

  // ----------------------------------------------------------------
  // Phase accumulator: 100 steps at freq Hz from a 20 MHz clock
  // ----------------------------------------------------------------
  logic [24:0] acc_r;
  logic [6:0] step_r;
  logic out_r;
  // Both operands widened first so the product is never cut at 11 bits
  wire logic [24:0] inc = {14'h0, freq_c} * {18'h0, `BRK_DUTY_FULL}; // see R6
  wire logic [24:0] sum = acc_r + inc;
  wire logic wrap = (sum >= `BRK_SYS_CLK_HZ);
  wire logic [24:0] acc_nxt = wrap ? 25'(sum - `BRK_SYS_CLK_HZ) : sum;
  wire logic last = (step_r == `BRK_PWM_STEP_LAST);
  wire logic [6:0] step_nxt = wrap ? (last ? 7'h00 : 7'(step_r + 7'h01)) : step_r;
  wire logic out_nxt = active ? (step_nxt < duty_c) : pwm.release_brake; // see R8

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_r <= 25'h0;
      step_r <= 7'h00;
      out_r <= 1'b0;
    end else begin
      acc_r <= active ? acc_nxt : 25'h0;
      step_r <= active ? step_nxt : 7'h00;
      out_r <= out_nxt;
    end
  end

  assign pwm.pwm_out = out_r;

endmodule
`default_nettype wire

// ===== logic/brkseq_top.sv
// Purpose: Holding-brake sequencer with delay timers and brake PWM
// Assumes: Drive status inputs come from logic on sys_clk
// Notes: Configuration entries are reached by subindex over a plain strobe port
`timescale 1ns/10ps
`default_nettype none
`include "brkseq_regs.svh"
module brkseq_top #(
  parameter int unsigned MS_CYCLES = `BRK_SYS_CLK_HZ / `BRK_HZ_PER_KHZ * `BRK_TICK_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Configuration entry access
  input wire logic [7:0] od_subidx,
  input wire logic od_wr,
  input wire logic od_rd,
  input wire logic [31:0] od_wdata,
  output logic [31:0] od_rdata,
  output logic od_ack,
  output logic od_err,
  // Drive state machine
  input wire logic drive_enable,
  input wire logic motor_standstill,
  output logic op_ready,
  output logic [2:0] seq_state,
  // Power stage and brake
  output logic power_stage_en,
  output logic brake_released,
  output logic brake_out
);

  // ----------------------------------------------------------------
  // Configuration entries
  // ----------------------------------------------------------------
  logic [31:0] close_brake_idle_delay_r;
  logic [31:0] power_off_idle_delay_r;
  logic [31:0] open_brake_delay_r;
  logic [31:0] start_operation_delay_r;
  logic [31:0] brake_pwm_frequency_r;
  logic [31:0] brake_pwm_duty_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic err_r;

  wire logic hit_count = (od_subidx == `BRK_SUB_COUNT);
  wire logic hit_close = (od_subidx == `BRK_SUB_CLOSE);
  wire logic hit_power = (od_subidx == `BRK_SUB_POWER);
  wire logic hit_open = (od_subidx == `BRK_SUB_OPEN);
  wire logic hit_start = (od_subidx == `BRK_SUB_START);
  wire logic hit_freq = (od_subidx == `BRK_SUB_FREQ);
  wire logic hit_duty = (od_subidx == `BRK_SUB_DUTY);
  wire logic hit_rw = hit_close | hit_power | hit_open | hit_start | hit_freq | hit_duty;
  wire logic hit_any = hit_rw | hit_count;
  wire logic wr_ok = od_wr & hit_rw;
  // Writes to the read-only count and unknown subindices are dropped and flagged
  wire logic access_bad = (od_wr & !hit_rw) | (od_rd & !hit_any);

  wire logic [31:0] rd_mux =
    hit_count ? {24'h0, `BRK_ENTRY_COUNT} :
    hit_close ? close_brake_idle_delay_r :
    hit_power ? power_off_idle_delay_r :
    hit_open ? open_brake_delay_r :
    hit_start ? start_operation_delay_r :
    hit_freq ? brake_pwm_frequency_r :
    hit_duty ? brake_pwm_duty_r : 32'h0;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      close_brake_idle_delay_r <= `BRK_CLOSE_RST; // see R2
      power_off_idle_delay_r <= `BRK_POWER_RST; // see R3
      open_brake_delay_r <= `BRK_OPEN_RST; // see R4
      start_operation_delay_r <= `BRK_START_RST; // see R5
      brake_pwm_frequency_r <= `BRK_FREQ_RST; // see R6
      brake_pwm_duty_r <= `BRK_DUTY_RST; // see R7
    end else if (wr_ok) begin
      if (hit_close) begin
        close_brake_idle_delay_r <= od_wdata;
      end
      if (hit_power) begin
        power_off_idle_delay_r <= od_wdata;
      end
      if (hit_open) begin
        open_brake_delay_r <= od_wdata;
      end
      if (hit_start) begin
        start_operation_delay_r <= od_wdata;
      end
      if (hit_freq) begin
        brake_pwm_frequency_r <= od_wdata;
      end
      if (hit_duty) begin
        brake_pwm_duty_r <= od_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h0;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      // Read data reflects the entry before a same-cycle write lands
      rdata_r <= od_rd ? rd_mux : rdata_r;
      ack_r <= od_rd | od_wr;
      err_r <= access_bad;
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick, restarted with each delay
  // ----------------------------------------------------------------
  // Restarting the divider keeps every delay within one cycle of N ms
  logic [14:0] div_r;
  logic [31:0] ms_r;
  logic tmr_start;
  wire logic tick = (div_r == 15'(MS_CYCLES - 1)); // see R9
  wire logic ms_sat = (ms_r == 32'hffff_ffff);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 15'h0;
      ms_r <= 32'h0;
    end else if (tmr_start) begin
      div_r <= 15'h0;
      ms_r <= 32'h0;
    end else begin
      div_r <= tick ? 15'h0 : 15'(div_r + 15'h1);
      ms_r <= (tick && !ms_sat) ? 32'(ms_r + 32'h1) : ms_r; // see R1
    end
  end

  // Unsigned compare; a zero delay is reached on the first cycle of its state
  function automatic logic delay_done(input logic [31:0] elapsed, input logic [31:0] delay);
    delay_done = (elapsed >= delay); // see R1 see R9
  endfunction

  // ----------------------------------------------------------------
  // Brake sequencer
  // ----------------------------------------------------------------
  brkseq_pkg::brkseq_state_t state_r;
  brkseq_pkg::brkseq_state_t state_nxt;
  logic power_r;
  logic release_r;
  logic ready_r;

  wire logic open_done = delay_done(ms_r, open_brake_delay_r);
  wire logic start_done = delay_done(ms_r, start_operation_delay_r);
  wire logic close_done = delay_done(ms_r, close_brake_idle_delay_r);
  wire logic power_done = delay_done(ms_r, power_off_idle_delay_r);

  // A withdrawn enable during the open wait goes straight to the power wait; from the start wait on it runs the full shutdown path
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      brkseq_pkg::BRK_IDLE: begin
        if (drive_enable) begin
          state_nxt = brkseq_pkg::BRK_OPEN_WAIT;
        end
      end
      brkseq_pkg::BRK_OPEN_WAIT: begin
        if (!drive_enable) begin
          state_nxt = brkseq_pkg::BRK_POWER_WAIT;
        end else if (open_done) begin
          state_nxt = brkseq_pkg::BRK_START_WAIT; // see R4
        end
      end
      brkseq_pkg::BRK_START_WAIT: begin
        if (!drive_enable) begin
          state_nxt = brkseq_pkg::BRK_STILL_WAIT;
        end else if (start_done) begin
          state_nxt = brkseq_pkg::BRK_RUN; // see R5
        end
      end
      brkseq_pkg::BRK_RUN: begin
        if (!drive_enable) begin
          state_nxt = brkseq_pkg::BRK_STILL_WAIT;
        end
      end
      brkseq_pkg::BRK_STILL_WAIT: begin
        if (motor_standstill) begin
          state_nxt = brkseq_pkg::BRK_CLOSE_WAIT;
        end
      end
      brkseq_pkg::BRK_CLOSE_WAIT: begin
        if (close_done) begin
          state_nxt = brkseq_pkg::BRK_POWER_WAIT; // see R2
        end
      end
      brkseq_pkg::BRK_POWER_WAIT: begin
        if (power_done) begin
          state_nxt = brkseq_pkg::BRK_IDLE; // see R3
        end
      end
      default: begin
        state_nxt = brkseq_pkg::BRK_IDLE;
      end
    endcase
  end

  wire logic moving = (state_nxt != state_r);
  // Every timed state restarts the millisecond count on entry
  assign tmr_start = moving; // see R9

  wire logic power_nxt = (state_nxt != brkseq_pkg::BRK_IDLE); // see R3
  wire logic release_nxt = (state_nxt == brkseq_pkg::BRK_START_WAIT) ||
                           (state_nxt == brkseq_pkg::BRK_RUN) ||
                           (state_nxt == brkseq_pkg::BRK_STILL_WAIT) ||
                           (state_nxt == brkseq_pkg::BRK_CLOSE_WAIT); // see R2 see R4
  wire logic ready_nxt = (state_nxt == brkseq_pkg::BRK_RUN); // see R5

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= brkseq_pkg::BRK_IDLE;
      power_r <= 1'b0;
      release_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      power_r <= power_nxt;
      release_r <= release_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Brake PWM
  // ----------------------------------------------------------------
  brkseq_pwm_if pwm_bus ();

  assign pwm_bus.freq = brake_pwm_frequency_r; // see R6
  assign pwm_bus.duty = brake_pwm_duty_r; // see R7
  assign pwm_bus.release_brake = release_r; // see R8

  brkseq_pwm u_pwm (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pwm(pwm_bus.gen)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign od_rdata = rdata_r;
  assign od_ack = ack_r;
  assign od_err = err_r;
  assign op_ready = ready_r;
  assign seq_state = state_r;
  assign power_stage_en = power_r;
  assign brake_released = release_r;
  assign brake_out = pwm_bus.pwm_out;

endmodule
`default_nettype wire

// ===== sim/brkseq_motor.sv
// Purpose: Motor and holding brake beside the sequencer
// Assumes: Same clock as the sequencer
// Notes: Counts brake coil drive cycles for duty checks
`timescale 1ns/10ps
`default_nettype none
module brkseq_motor #(
  parameter int unsigned STOP = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Drive side
  input wire logic drive_enable,
  input wire logic power_stage_en,
  input wire logic brake_out,
  // Motor and brake
  output logic motor_standstill,
  output logic [31:0] on_cnt
);
  logic [7:0] coast_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      coast_r <= 8'h00;
      on_cnt <= 32'h0;
    end else begin
      coast_r <= (drive_enable || !power_stage_en) ? 8'h00 : coast_r + {7'h00, coast_r != 8'hff};
      on_cnt <= on_cnt + {31'h0, brake_out};
    end
  end
  // Coasts STOP cycles after motion is withdrawn, so standstill lags
  assign motor_standstill = !power_stage_en || (coast_r >= 8'(STOP));
endmodule
`default_nettype wire

// ===== sim/brkseq_props.sv
// Purpose: Port assertions for the brake sequencer
// Assumes: Single sys_clk domain, bound from tb
// Notes: State codes follow the sequencer's state register
`timescale 1ns/10ps
`default_nettype none
module brkseq_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Entry access
  input wire logic [7:0] od_subidx,
  input wire logic od_wr,
  input wire logic od_rd,
  input wire logic od_ack,
  input wire logic od_err,
  // Sequencer
  input wire logic drive_enable,
  input wire logic motor_standstill,
  input wire logic op_ready,
  input wire logic [2:0] seq_state,
  input wire logic power_stage_en,
  input wire logic brake_released,
  input wire logic brake_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Steps of switch-on and shutdown, and entry access checks
  // ----------------------------------------
  sequence s_go; seq_state == 3'h0 && drive_enable; endsequence
  sequence s_pow; seq_state == 3'h1 && power_stage_en && !brake_released; endsequence
  property p_ack; od_wr || od_rd |=> od_ack; endproperty
  property p_ro; od_wr && od_subidx == 8'h00 |=> od_err; endproperty
  property p_on; s_go |=> s_pow; endproperty
  property p_rel; $changed(seq_state) && seq_state == 3'h2 |-> $past(seq_state) == 3'h1; endproperty
  property p_run; seq_state == 3'h3 |-> op_ready && brake_released && power_stage_en; endproperty
  property p_still; seq_state == 3'h4 && !motor_standstill |=> seq_state == 3'h4; endproperty
  property p_close; seq_state == 3'h6 |-> power_stage_en && !brake_released; endproperty
  property p_idle; seq_state == 3'h0 |-> !power_stage_en && !brake_released && !op_ready; endproperty
  property p_brk; !brake_released |=> !brake_out; endproperty
  a_ack: assert property (p_ack) else $error("no ack after access");
  a_ro: assert property (p_ro) else $error("count entry write not refused");
  a_on: assert property (p_on) else $error("power not on after enable");
  a_rel: assert property (p_rel) else $error("release without open wait");
  a_run: assert property (p_run) else $error("run outputs wrong");
  a_still: assert property (p_still) else $error("left standstill wait early");
  a_close: assert property (p_close) else $error("power wait outputs wrong");
  a_idle: assert property (p_idle) else $error("idle outputs wrong");
  a_brk: assert property (p_brk) else $error("brake driven while closed");
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Purpose: Self-checking bench for the brake sequencer
// Assumes: MS_CYCLES shortened to 4
// Notes: Inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic od_wr = 1'b0;
  logic od_rd = 1'b0;
  logic drive_enable = 1'b0;
  logic [7:0] od_subidx = 8'h00;
  logic [31:0] od_wdata = 32'h0;
  logic [31:0] od_rdata, on_cnt, on_a;
  logic od_ack, od_err, op_ready, power_stage_en, brake_released, brake_out, motor_standstill;
  logic [2:0] seq_state;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [31:0] rst [7] = '{32'h6, 32'h3e8, 32'h3e8, 32'h3e8, 32'h0, 32'h0, 32'h0};
  logic [31:0] cfg [2][6] = '{'{32'h1, 32'h0, 32'h2, 32'h0, 32'h7d0, 32'h2},
                              '{32'h0, 32'h2, 32'h0, 32'h1, 32'h7d0, 32'h64}};
  always #25 sys_clk = ~sys_clk;
  brkseq_top #(.MS_CYCLES(4)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .od_subidx(od_subidx),
    .od_wr(od_wr), .od_rd(od_rd), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack),
    .od_err(od_err), .drive_enable(drive_enable), .motor_standstill(motor_standstill),
    .op_ready(op_ready), .seq_state(seq_state), .power_stage_en(power_stage_en),
    .brake_released(brake_released), .brake_out(brake_out));
  brkseq_motor u_motor (.sys_clk(sys_clk), .resetn(resetn), .drive_enable(drive_enable),
    .power_stage_en(power_stage_en), .brake_out(brake_out), .motor_standstill(motor_standstill),
    .on_cnt(on_cnt));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Reads compare against d, writes store d
  task automatic acc(logic w, logic [7:0] s, logic [31:0] d, logic e);
    @(negedge sys_clk);
    od_wr = w;
    od_rd = !w;
    od_subidx = s;
    od_wdata = d;
    @(negedge sys_clk);
    od_wr = 1'b0;
    od_rd = 1'b0;
    chk("ack", {31'h0, od_ack}, 32'h1);
    chk("err", {31'h0, od_err}, {31'h0, e});
    if (!w) chk("rdata", od_rdata, d);
  endtask
  // N ms of 4-cycle ticks, plus the edge on which the compare is seen
  function automatic int cyc(logic [31:0] n);
    return 4 * int'(n) + 1;
  endfunction
  // Cycles spent before seq_state shows s
  task automatic dwell(logic [2:0] s, int exp);
    int n;
    n = 0;
    while (seq_state !== s && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 20000) begin
      n_mismatch++;
      finish_test();
    end else begin
      chk("dwell", n, exp);
    end
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    for (int s = 0; s < 7; s++) acc(1'b0, 8'(s), rst[s], 1'b0);
    acc(1'b0, 8'h07, 32'h0, 1'b1);
    acc(1'b1, 8'h00, 32'h9, 1'b1);
    acc(1'b0, 8'h00, 32'h6, 1'b0);
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 6; k++) begin
        acc(1'b1, 8'(k + 1), cfg[p][k], 1'b0);
        acc(1'b0, 8'(k + 1), cfg[p][k], 1'b0);
      end
      @(negedge sys_clk);
      drive_enable = 1'b1;
      dwell(3'h1, 1);
      dwell(3'h2, cyc(cfg[p][2]));
      dwell(3'h3, cyc(cfg[p][3]));
      // One whole PWM period at 2000 Hz is 10000 cycles
      on_a = on_cnt;
      repeat (10000) @(negedge sys_clk);
      chk("brake_on", on_cnt - on_a, cfg[p][5] * 32'h64);
      drive_enable = 1'b0;
      dwell(3'h4, 1);
      dwell(3'h5, 6);
      dwell(3'h6, cyc(cfg[p][0]));
      dwell(3'h0, cyc(cfg[p][1]));
    end
    finish_test();
  end
endmodule
bind brkseq_top brkseq_props u_props (.sys_clk(sys_clk), .resetn(resetn), .od_subidx(od_subidx),
  .od_wr(od_wr), .od_rd(od_rd), .od_ack(od_ack), .od_err(od_err), .drive_enable(drive_enable),
  .motor_standstill(motor_standstill), .op_ready(op_ready), .seq_state(seq_state),
  .power_stage_en(power_stage_en), .brake_released(brake_released), .brake_out(brake_out));
`default_nettype wire
